// >>> hpf_map.svh
// Offsets, field positions, reset values and timing counts of the host port
`ifndef HPF_MAP_SVH
`define HPF_MAP_SVH

`define HPF_CLK_PERIOD_NS  100
`define HPF_ADDR_W         10
`define HPF_DATA_W         8
`define HPF_ADDR_GO        10'h000
`define HPF_ADDR_CDIO      10'h030
`define HPF_ADDR_STATUS1   10'h001
`define HPF_ADDR_STATUS0   10'h002
`define HPF_ADDR_MODE      10'h003
`define HPF_ADDR_EVENT     10'h004
`define HPF_MODE_ENC_BIT   0
`define HPF_MODE_XFER_LSB  1
`define HPF_MODE_RESET     8'h01
`define HPF_ST1_RDY_BIT    0
`define HPF_ST1_BUSY_BIT   1
`define HPF_ST1_ENC_BIT    2
`define HPF_STATUS_RESET   8'h00
`define HPF_MEM_DEPTH      1024

`endif

// >>> hpf_pkg.sv
// Types shared by the host port block
package hpf_pkg;
    // Compressed data transfer submode
    typedef enum logic [1:0] {
        HPF_XFER_MASTER = 2'h0,
        HPF_XFER_SLAVE  = 2'h1,
        HPF_XFER_DMA    = 2'h2
    } hpf_xfer_t;

    // Code memory transfer sequencer, one-hot
    typedef enum logic [2:0] {
        HPF_CM_IDLE = 3'b001,
        HPF_CM_XFER = 3'b010,
        HPF_CM_WAIT = 3'b100
    } hpf_cm_state_t;

    // DMA handshake sequencer, one-hot
    typedef enum logic [2:0] {
        HPF_DMA_IDLE = 3'b001,
        HPF_DMA_REQ  = 3'b010,
        HPF_DMA_ACK  = 3'b100
    } hpf_dma_state_t;
endpackage

// >>> hpf_host_port.sv
// Host parallel port, status interrupts, DMA handshake and direction control
`timescale 1ns/1ps
// Overview of operation
// (R1) Busy code memory blocks writes/reads
// (R2) Busy before a cycle skips that cycle
// (R3) Memory holds busy at least one clock
// (R4) Host drives ten-bit internal address
// (R5) Eight-bit data, code bus extends it
// (R6) Write data captured at write strobe rise
// (R7) Host uses select, read, write strobes
// (R8) General interrupt on any non-ready status flag
// (R9) General interrupt cleared by read/reset/launch
// (R10) Data-ready interrupt follows data-ready flag
// (R11) Data-ready cleared by status/data access
// (R12) Acknowledge held for whole DMA cycle
// (R13) No new request until acknowledge released
// (R14) Request withdrawn by reset or acknowledge
// (R15) Direction high encoding, low decoding
// (R16) Direction changes only on mode fetch
// (R17) Scan pins turn one clock later
// (R18) Reset forces direction high
// (R19) Decode end-of-scan is one-clock output
// (R20) Launch is write to address zero
// (R21) Data bus driven only on selected read
`include "hpf_map.svh"

module hpf_host_port #(
    parameter int ADDR_W = `HPF_ADDR_W,
    parameter int DATA_W = `HPF_DATA_W
) (
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  srst_i,
    // Host strobes and address
    input  wire logic                  cs_n_i,
    input  wire logic                  rd_n_i,
    input  wire logic                  wr_n_i,
    input  wire logic [ADDR_W-1:0]     addr_i,
    // Data bus, low byte and code extension
    input  wire logic [2*DATA_W-1:0]   data_i,
    output logic      [2*DATA_W-1:0]   data_o,
    output logic                       data_oe_o,
    output logic                       data_hi_oe_o,
    // Interrupts
    output logic                       irq_n_o,
    output logic                       data_ready_irq_n_o,
    // DMA handshake
    input  wire logic                  dma_ack_n_i,
    output logic                       dma_req_n_o,
    // Code memory busy
    input  wire logic                  code_mem_busy_n_i,
    // Core side compressed byte stream, producer into host port (encode)
    input  wire logic                  core_valid_i,
    input  wire logic [DATA_W-1:0]     core_data_i,
    output logic                       core_ready_o,
    // Host bytes toward core (decode)
    output logic                       core_in_valid_o,
    output logic      [DATA_W-1:0]     core_in_data_o,
    input  wire logic                  core_in_ready_i,
    // Core status events and scan end
    input  wire logic [DATA_W-1:0]     status_set_i,
    input  wire logic                  scan_last_i,
    // Direction and scan pins
    output logic                       comp_o,
    output logic                       scan_pins_out_o,
    output logic                       end_of_scan_n_o,
    output logic                       end_of_scan_oe_o,
    // Master mode code memory cycle strobe
    output logic                       code_cycle_o,
    output hpf_pkg::hpf_xfer_t         xfer_mode_o
);
    import hpf_pkg::*;

    // Only the documented widths are served
    if (ADDR_W != `HPF_ADDR_W || DATA_W != `HPF_DATA_W) begin : g_bad_width
        $error("hpf_host_port: widths must be 10 and 8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe decoding
    ////////////////////////////////////////////////////////////////////////////
    logic                 wr_n_d_r;     // Write strobe of previous clock
    logic                 rd_n_d_r;     // Read strobe of previous clock
    logic                 cs_wr_r;      // Select seen while write was low
    logic [ADDR_W-1:0]    wr_addr_r;    // Address held across write pulse
    logic [2*DATA_W-1:0]  wr_data_r;    // Data held across write pulse
    wire                  wr_rise;      // Write strobe rising edge
    wire                  rd_fall;      // Read strobe start
    wire                  rd_act;       // Selected read in progress
    wire                  hit_go;       // Launch address
    wire                  hit_cdio;     // Compressed data register
    wire                  hit_st1;      // First status register
    wire                  hit_st0;      // General status register

    // Write ends at rising strobe, data taken then (see R6) (see R7)
    assign wr_rise  = wr_n_i & ~wr_n_d_r & cs_wr_r;
    // Read qualified by select, or by acknowledge in a DMA cycle
    assign rd_act   = ~rd_n_i & ~(cs_n_i & dma_ack_n_i);     // see R7
    assign rd_fall  = rd_act & rd_n_d_r;
    assign hit_go   = (wr_addr_r == ADDR_W'(`HPF_ADDR_GO));  // see R20
    assign hit_cdio = (addr_i == ADDR_W'(`HPF_ADDR_CDIO));   // see R4
    assign hit_st1  = (addr_i == ADDR_W'(`HPF_ADDR_STATUS1));
    assign hit_st0  = (addr_i == ADDR_W'(`HPF_ADDR_STATUS0));

    // Strobe history and write capture while pulse is low
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_n_d_r  <= 1'b1;
            rd_n_d_r  <= 1'b1;
            cs_wr_r   <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            wr_n_d_r <= wr_n_i;
            rd_n_d_r <= rd_n_i | (cs_n_i & dma_ack_n_i);
            if (!wr_n_i) begin
                // Last sample before the edge is the latched value
                cs_wr_r   <= ~cs_n_i;
                wr_addr_r <= addr_i;
                wr_data_r <= data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal memory and mode register
    ////////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] mem_r [`HPF_MEM_DEPTH];  // Internal memory image
    logic [DATA_W-1:0] mode_r;                  // Active mode, fetched on launch
    logic              fetch_r;                 // Mode fetch pending after launch
    wire               launch;                  // Host launch command
    wire               cdio_wr;                 // Host write of compressed data

    assign launch  = wr_rise & hit_go;
    assign cdio_wr = wr_rise & (wr_addr_r == ADDR_W'(`HPF_ADDR_CDIO));

    // Host writes to memory; launch address is virtual, not stored
    always_ff @(posedge mclk_i) begin
        if (wr_rise && !hit_go) begin
            mem_r[wr_addr_r] <= wr_data_r[DATA_W-1:0];
        end
    end

    // Mode fetched one clock after launch, only point of change (see R16)
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            mode_r  <= `HPF_MODE_RESET;                        // see R18
            fetch_r <= 1'b0;
        end else begin
            fetch_r <= launch;
            if (fetch_r) begin
                mode_r <= mem_r[`HPF_ADDR_MODE];
            end
        end
    end

    wire       enc_mode = mode_r[`HPF_MODE_ENC_BIT];
    hpf_xfer_t xfer;
    assign xfer = hpf_xfer_t'(mode_r[`HPF_MODE_XFER_LSB +: 2]);
    wire       wide = (xfer != HPF_XFER_MASTER);               // see R5

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry outbound buffer between core and host port
    ////////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] buf_r [2];   // Buffer entries
    logic              wp_r;        // Write pointer
    logic              rp_r;        // Read pointer
    logic [1:0]        cnt_r;       // Fill level
    wire               buf_full  = (cnt_r == 2'h2);
    wire               buf_empty = (cnt_r == 2'h0);
    wire               pop;         // Host or code memory consumes a byte
    wire               push = core_valid_i & ~buf_full & enc_mode;
    wire               cdio_rd = rd_fall & hit_cdio;
    wire               pop_two = cdio_rd & wide & buf_full;  // Wide read takes both bytes

    // Buffer drains on host read of data register or master cycle
    assign pop = ~buf_empty & (cdio_rd | (code_cycle_o & enc_mode));

    // Buffer pointer and storage update
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                buf_r[wp_r] <= core_data_i;
                wp_r        <= ~wp_r;
            end
            // A wide read consumes both entries and leaves the pointer
            if (pop && !pop_two) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop} - {1'b0, pop_two};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Code memory cycle sequencer (master mode)
    ////////////////////////////////////////////////////////////////////////////
    hpf_cm_state_t cm_r;     // Sequencer state
    hpf_cm_state_t cm_nxt;   // Next state
    wire cm_have = enc_mode ? ~buf_empty : core_in_ready_i;
    wire cm_go   = (xfer == HPF_XFER_MASTER) & cm_have;

    // Busy sampled a clock ahead skips the coming cycle (see R1) (see R2)
    always_comb begin
        case (cm_r)
            HPF_CM_IDLE: cm_nxt = (cm_go && code_mem_busy_n_i) ? HPF_CM_XFER : HPF_CM_IDLE;
            HPF_CM_XFER: cm_nxt = HPF_CM_WAIT;
            HPF_CM_WAIT: cm_nxt = HPF_CM_IDLE;
            default:     cm_nxt = HPF_CM_IDLE;
        endcase
    end

    // Sequencer register; busy width of one clock relied upon (see R3)
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cm_r         <= HPF_CM_IDLE;
            code_cycle_o <= 1'b0;
        end else begin
            cm_r         <= cm_nxt;
            code_cycle_o <= (cm_nxt == HPF_CM_XFER);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and interrupts
    ////////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] status0_r;      // Sticky general status flags
    logic              rdy_r;          // Data-ready flag
    logic              rdy_rise_blk_r; // Holds off re-set until access completes
    wire               st0_rd = rd_fall & hit_st0;
    wire               st1_rd = rd_fall & hit_st1;
    wire               rdy_set = (xfer != HPF_XFER_MASTER) &
                                 (enc_mode ? ~buf_empty : core_in_ready_i);
    wire               rdy_clr = st1_rd | cdio_rd | cdio_wr;
    // Ready is a level condition, so it re-arms only after the access ends
    wire               rdy_nxt = ~rdy_clr & ((rdy_set & ~rdy_rise_blk_r) | rdy_r);

    // Flag update; a status event in the clearing cycle wins
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            status0_r <= `HPF_STATUS_RESET;
            rdy_r     <= 1'b0;
        end else begin
            status0_r <= ((st0_rd | launch) ? '0 : status0_r) | status_set_i;
            rdy_r     <= rdy_nxt;
        end
    end

    // Blocking window of the ready flag
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdy_rise_blk_r <= 1'b0;
        end else begin
            rdy_rise_blk_r <= rdy_clr | (rdy_rise_blk_r & (rd_act | ~wr_n_i));
        end
    end

    // Interrupt pins from flip-flops
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_n_o            <= 1'b1;                                // see R9
            data_ready_irq_n_o <= 1'b1;                                // see R11
        end else begin
            // Data-ready flag excluded from general line (see R8) (see R9)
            irq_n_o <= ~(|(((st0_rd | launch) ? '0 : status0_r) | status_set_i));
            // Slave mode only (see R10) (see R11)
            data_ready_irq_n_o <= ~((xfer == HPF_XFER_SLAVE) & rdy_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DMA handshake
    ////////////////////////////////////////////////////////////////////////////
    hpf_dma_state_t dma_r;   // Handshake state
    hpf_dma_state_t dma_nxt; // Next state

    // Request, withdraw on ack, wait for ack release (see R13) (see R14)
    always_comb begin
        case (dma_r)
            HPF_DMA_IDLE: dma_nxt = ((xfer == HPF_XFER_DMA) && rdy_set && dma_ack_n_i) ?
                                    HPF_DMA_REQ : HPF_DMA_IDLE;
            HPF_DMA_REQ:  dma_nxt = !dma_ack_n_i ? HPF_DMA_ACK : HPF_DMA_REQ;
            HPF_DMA_ACK:  dma_nxt = dma_ack_n_i ? HPF_DMA_IDLE : HPF_DMA_ACK;  // see R12
            default:      dma_nxt = HPF_DMA_IDLE;
        endcase
    end

    // Handshake register and request pin
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dma_r       <= HPF_DMA_IDLE;
            dma_req_n_o <= 1'b1;                                       // see R14
        end else begin
            dma_r       <= dma_nxt;
            dma_req_n_o <= ~(dma_nxt == HPF_DMA_REQ);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, bus drive and inbound bytes
    ////////////////////////////////////////////////////////////////////////////
    wire [DATA_W-1:0] rd_lo = hit_cdio ? buf_r[rp_r] :
                              hit_st1  ? {5'h00, enc_mode, ~code_mem_busy_n_i, rdy_r} :
                              hit_st0  ? status0_r :
                              mem_r[addr_i];
    wire [DATA_W-1:0] rd_hi = (hit_cdio && cnt_r == 2'h2) ? buf_r[~rp_r] : '0;
    wire              dma_ack_n_rd = (xfer == HPF_XFER_DMA) & ~dma_ack_n_i & ~rd_n_i;

    // Bus drive only during selected read (see R21) (see R5)
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            data_o         <= '0;
            data_oe_o      <= 1'b0;
            data_hi_oe_o   <= 1'b0;
            core_in_valid_o <= 1'b0;
            core_in_data_o <= '0;
        end else begin
            // Read data taken as the read starts, held for its length
            if (rd_fall) begin
                data_o <= {rd_hi, rd_lo};
            end
            data_oe_o    <= rd_act | dma_ack_n_rd;
            data_hi_oe_o <= (rd_act | dma_ack_n_rd) & wide;
            if (cdio_wr && !enc_mode) begin
                core_in_valid_o <= 1'b1;
                core_in_data_o  <= wr_data_r[DATA_W-1:0];
            end else if (core_in_ready_i) begin
                core_in_valid_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Direction and scan pins
    ////////////////////////////////////////////////////////////////////////////
    // Direction follows mode; scan pins turn a clock later (see R15) (see R17)
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            comp_o           <= 1'b1;                                  // see R18
            scan_pins_out_o  <= 1'b0;
            end_of_scan_n_o  <= 1'b1;
            end_of_scan_oe_o <= 1'b0;
            core_ready_o     <= 1'b0;
            xfer_mode_o      <= HPF_XFER_MASTER;
        end else begin
            comp_o           <= enc_mode;
            scan_pins_out_o  <= ~comp_o;
            end_of_scan_oe_o <= ~comp_o;
            // One-clock pulse with last decoded sample (see R19)
            end_of_scan_n_o  <= ~(scan_last_i & ~comp_o);
            core_ready_o     <= (cnt_r == 2'h0) | ((cnt_r == 2'h1) & ~push);
            xfer_mode_o      <= xfer;
        end
    end
endmodule

// >>> hpf_host_port_chk.sv
// Checker of host port timing relations
`timescale 1ns/1ps
`include "hpf_map.svh"
module hpf_host_port_chk #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 8
) (
    // Clock, reset, host strobes
    input wire logic              mclk_i,
    input wire logic              srst_i,
    input wire logic              cs_n_i,
    input wire logic              rd_n_i,
    input wire logic              wr_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    // Handshakes and events
    input wire logic              dma_ack_n_i,
    input wire logic              dma_req_n_o,
    input wire logic              code_mem_busy_n_i,
    input wire logic              code_cycle_o,
    input wire logic [DATA_W-1:0] status_set_i,
    // Status outputs
    input wire logic              irq_n_o,
    input wire logic              data_ready_irq_n_o,
    input wire logic              data_oe_o,
    input wire logic              comp_o,
    input wire logic              scan_pins_out_o,
    input wire logic              end_of_scan_n_o,
    input wire logic              end_of_scan_oe_o,
    input wire hpf_pkg::hpf_xfer_t xfer_mode_o
);
    import hpf_pkg::*;
    logic       wr_q_r;   // Write strobe one clock back
    logic       sel0_r;   // Launch address selected one clock back
    logic [3:0] since_r;  // Clocks since launch, saturating
    // Launch taken, status read, data access, selected read
    wire launch = wr_n_i && !wr_q_r && sel0_r;
    wire st_rd  = !cs_n_i && !rd_n_i && addr_i == `HPF_ADDR_STATUS0;
    wire cd_acc = !cs_n_i && !(rd_n_i && wr_n_i)
                  && (addr_i == `HPF_ADDR_CDIO || addr_i == `HPF_ADDR_STATUS1);
    wire rd_sel = !rd_n_i && !(cs_n_i && dma_ack_n_i);
    // Track launch writes
    always_ff @(posedge mclk_i) begin
        wr_q_r <= wr_n_i;
        sel0_r <= !cs_n_i && addr_i == `HPF_ADDR_GO;
        if (srst_i || since_r != 4'hF) begin
            since_r <= srst_i ? 4'hF : since_r + 4'h1;
        end
        if (launch && !srst_i) begin
            since_r <= 4'h0;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // One-clock low pulse of end of scan
    sequence s_eos_pulse;
        !end_of_scan_n_o ##1 end_of_scan_n_o;
    endsequence
    a_comp_reset: assert property ($fell(srst_i) |-> comp_o && irq_n_o && dma_req_n_o)
        else $error("outputs wrong after reset");
    a_comp_launch: assert property ($changed(comp_o) |-> since_r <= 4'h4)
        else $error("direction changed without launch");
    a_scan_turn: assert property (scan_pins_out_o == !$past(comp_o))
        else $error("scan pins did not turn one clock later");
    a_irq_set: assert property (|status_set_i |=> !irq_n_o)
        else $error("general interrupt not raised");
    a_irq_clear: assert property ((st_rd || launch) && status_set_i == '0 |=> irq_n_o)
        else $error("general interrupt not cleared");
    a_req_drop: assert property (!dma_ack_n_i |=> dma_req_n_o)
        else $error("request not withdrawn on acknowledge");
    a_req_wait: assert property ($fell(dma_req_n_o) |-> $past(dma_ack_n_i))
        else $error("request raised while acknowledge low");
    a_data_ready_irq_n_clr: assert property (cd_acc |-> ##[1:4] data_ready_irq_n_o)
        else $error("data ready interrupt not cleared");
    a_data_ready_irq_n_mode: assert property (!data_ready_irq_n_o |-> xfer_mode_o == HPF_XFER_SLAVE)
        else $error("data ready interrupt outside slave mode");
    a_oe_read: assert property (data_oe_o |-> $past(rd_sel))
        else $error("data bus driven without read");
    a_busy_skip: assert property (!code_mem_busy_n_i ##1 !code_mem_busy_n_i |-> !code_cycle_o)
        else $error("code memory cycle while busy");
    a_eos_pulse: assert property ($fell(end_of_scan_n_o) |-> !comp_o && end_of_scan_oe_o ##0 s_eos_pulse)
        else $error("end of scan pulse malformed");
endmodule
bind hpf_host_port hpf_host_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .mclk_i, .srst_i, .cs_n_i, .rd_n_i, .wr_n_i, .addr_i, .dma_ack_n_i,
    .dma_req_n_o, .code_mem_busy_n_i, .code_cycle_o, .status_set_i, .irq_n_o,
    .data_ready_irq_n_o, .data_oe_o, .comp_o, .scan_pins_out_o,
    .end_of_scan_n_o, .end_of_scan_oe_o, .xfer_mode_o
);

// >>> hpf_host_model.sv
// Host processor and DMA controller model
`timescale 1ns/1ps
module hpf_host_model (
    // Clock
    input  wire logic        mclk_i,
    // Strobes and address
    output logic             cs_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             dma_ack_n_o,
    output logic [9:0]       addr_o,
    // Data bus
    output logic [15:0]      bus_o,
    input  wire logic [15:0] dout_i,
    input  wire logic        oe_i,
    input  wire logic        hi_oe_i
);
    logic        drv;  // Host drives the bus
    logic [15:0] hd;   // Host write value
    // Bus level, pull-downs hold a released bus low
    assign bus_o[7:0]  = oe_i ? dout_i[7:0] : (drv ? hd[7:0] : 8'h00);
    assign bus_o[15:8] = hi_oe_i ? dout_i[15:8] : (drv ? hd[15:8] : 8'h00);
    initial begin
        {cs_n_o, rd_n_o, wr_n_o, dma_ack_n_o} = 4'hF;
        addr_o = 10'h000;
        drv = 1'b0;
        hd = 16'h0000;
    end
    // One access: strobe low 3 clocks, select held one clock past it
    task automatic cyc(input logic dma, input logic rd, input logic [9:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        addr_o = a;
        hd = d;
        drv = !rd;
        cs_n_o = dma;
        dma_ack_n_o = !dma;
        rd_n_o = !rd;
        wr_n_o = rd;
        repeat (3) @(posedge mclk_i);
        #10;
        q = bus_o;
        {rd_n_o, wr_n_o} = 2'h3;
        @(posedge mclk_i);
        #10;
        {cs_n_o, dma_ack_n_o, drv} = 3'h6;
        repeat (2) @(posedge mclk_i);
        #10;
    endtask
endmodule

// >>> hpf_host_port_test.sv
// Self-checking bench of the host port
`timescale 1ns/1ps
`include "hpf_map.svh"
module hpf_host_port_test;
    import hpf_pkg::*;
    logic        mclk_i, srst_i, cs_n, rd_n, wr_n, ack_n, busy_n, cvld, cin_rdy, slast;
    logic        oe, hi_oe, irq_n, data_ready_irq_n_n, dma_req_n_n, crdy, ivld, comp, spo, eos_n, eos_oe, ccyc;
    logic        last_eos = 1'b1;
    logic [9:0]  addr;
    logic [15:0] bus, dout, q;
    logic [7:0]  cdata, idata, sset, last_in;
    hpf_xfer_t   xmode;
    int          n_mismatch = 0, n_tests = 0, ncyc = 0, k, cnt;
    hpf_host_port dut (.mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .wr_n_i(wr_n), .addr_i(addr), .data_i(bus), .data_o(dout), .data_oe_o(oe),
        .data_hi_oe_o(hi_oe), .irq_n_o(irq_n), .data_ready_irq_n_o(data_ready_irq_n_n),
        .dma_ack_n_i(ack_n), .dma_req_n_o(dma_req_n_n), .code_mem_busy_n_i(busy_n),
        .core_valid_i(cvld), .core_data_i(cdata), .core_ready_o(crdy),
        .core_in_valid_o(ivld), .core_in_data_o(idata), .core_in_ready_i(cin_rdy),
        .status_set_i(sset), .scan_last_i(slast), .comp_o(comp), .scan_pins_out_o(spo),
        .end_of_scan_n_o(eos_n), .end_of_scan_oe_o(eos_oe), .code_cycle_o(ccyc),
        .xfer_mode_o(xmode));
    hpf_host_model host (.mclk_i(mclk_i), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .dma_ack_n_o(ack_n), .addr_o(addr), .bus_o(bus), .dout_i(dout), .oe_i(oe),
        .hi_oe_i(hi_oe));
    // Clock, 100 ns period
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // Capture bytes toward core and end of scan pulses
    always @(posedge mclk_i) begin
        if (ivld && cin_rdy) last_in <= idata;
        if (eos_oe && !eos_n) last_eos <= 1'b0;
    end
    // Hang limit
    always @(posedge mclk_i) begin
        ncyc++;
        if (ncyc == 5000) begin
            n_mismatch++;
            final_report;
        end
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk_i);
        #10;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host.cyc(1'b0, 1'b0, a, {8'h00, d}, q);
    endtask
    task automatic go(input logic [7:0] m);
        wr(`HPF_ADDR_MODE, m);
        wr(`HPF_ADDR_GO, 8'h00);
        idle(4);
    endtask
    // Offer one byte from the core, held until accepted
    task automatic push(input logic [7:0] b);
        cvld = 1'b1;
        cdata = b;
        for (k = 0; k < 20 && crdy !== 1'b1; k++) idle(1);
        idle(1);
        cvld = 1'b0;
    endtask
    task automatic t_irq;
        sset = 8'h04;
        idle(1);
        sset = 8'h00;
        idle(1);
        chk(irq_n, 1'b0);
        host.cyc(1'b0, 1'b1, `HPF_ADDR_STATUS0, 16'h0000, q);
        chk(irq_n, 1'b1);
        sset = 8'h80;
        idle(1);
        sset = 8'h00;
        go(`HPF_MODE_RESET);
        chk(irq_n, 1'b1);
        $display("test interrupt done");
    endtask
    task automatic t_busy;
        busy_n = 1'b0;
        push(8'h77);
        cnt = 0;
        for (k = 0; k < 10; k++) begin idle(1); cnt += ccyc; end
        chk(cnt, 0);
        busy_n = 1'b1;
        cnt = 0;
        for (k = 0; k < 10; k++) begin idle(1); cnt += ccyc; end
        chk(cnt != 0, 1'b1);
        $display("test busy done");
    endtask
    task automatic t_dma;
        go(8'h05);
        push(8'hC3);
        for (k = 0; k < 20 && dma_req_n_n !== 1'b0; k++) idle(1);
        chk(dma_req_n_n, 1'b0);
        host.cyc(1'b1, 1'b1, `HPF_ADDR_CDIO, 16'h0000, q);
        chk({q[7:0], dma_req_n_n}, {8'hC3, 1'b1});
        $display("test dma done");
    endtask
    task automatic t_enc_slave;
        go(8'h03);
        push(8'hA5);
        idle(2);
        chk(data_ready_irq_n_n, 1'b0);
        push(8'h3C);
        idle(1);
        chk(crdy, 1'b0);
        host.cyc(1'b0, 1'b1, `HPF_ADDR_CDIO, 16'h0000, q);
        chk(q, 16'h3CA5);
        chk({data_ready_irq_n_n, crdy}, 2'h3);
        $display("test encode slave done");
    endtask
    task automatic t_dec_slave;
        wr(`HPF_ADDR_MODE, 8'h02);
        chk(comp, 1'b1);
        go(8'h02);
        chk({comp, spo}, 2'h1);
        cin_rdy = 1'b1;
        idle(2);
        chk(data_ready_irq_n_n, 1'b0);
        wr(`HPF_ADDR_CDIO, 8'h5A);
        chk(last_in, 8'h5A);
        slast = 1'b1;
        idle(1);
        slast = 1'b0;
        idle(3);
        chk(last_eos, 1'b0);
        $display("test decode slave done");
    endtask
    initial begin
        {srst_i, busy_n, cvld, cin_rdy, slast} = 5'h18;
        cdata = 8'h00;
        sset = 8'h00;
        repeat (2) @(posedge mclk_i);
        #10;
        srst_i = 1'b0;
        chk({comp, irq_n, data_ready_irq_n_n, dma_req_n_n, oe}, 5'h1E);
        t_irq;
        t_busy;
        t_dma;
        t_enc_slave;
        t_dec_slave;
        final_report;
    end
endmodule
